// ==== rtl/tcl_pkg.sv ====
// shared constants and types for the timer control logic
package tcl_pkg;
  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_CTRL      = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'h95;
  // field positions of the control register
  localparam int BIT_HIGH_FLAG  = 7;
  localparam int BIT_LOW_FLAG   = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_UNUSED     = 1;
  localparam int BIT_EXT_CLOCK  = 0;
  // reset values and fixed patterns
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_MAX     = 8'hff;
  localparam logic [15:0] WORD_MAX     = 16'hffff;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;
  // prescaler ratios
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
  // control register image, bit 7 first
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_mode_enable;
    logic split_mode_select;
    logic run_control;
    logic unused;
    logic ext_clock_select;
  } tcl_ctrl_t;
  // one bus access
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcl_sfr_t;
endpackage

// ==== rtl/tcl_timer3_ctrl.sv ====
// 16-bit or dual 8-bit auto-reload timer with control/status register
//
// Operation
// - high byte wrap sets high overflow flag
// - 16-bit mode flag on full word wrap
// - enabled high flag raises interrupt request
// - low byte wrap sets low flag always
// - flags never cleared by hardware
// - low irq enable adds low overflow interrupts
// - bit 4 enables capture mode
// - split bit selects 16-bit or two 8-bit
// - run bit starts; clear halts 16-bit
// - split: run gates only high byte
// - bit 1 reads zero, writes ignored
// - ext select: sysclk/12 or ext/8 synced
// - split: ext select applies to both bytes
// - 16-bit wrap loads 16-bit reload value
// - split: each byte reloads its own
// - capture copies count, sets high flag
// - fast select bit counts system clock; 16-bit mode uses the low bit only
`timescale 1ns/1ps
module tcl_timer3_ctrl
  import tcl_pkg::*;
#(
  parameter int SYS_DIV = SYS_DIVIDE,
  parameter int EXT_DIV = EXT_DIVIDE
)(
  // clock and reset
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_N,
  // special function register bus
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic       I_SFR_WR,
  input  wire logic [7:0] I_SFR_WDATA,
  output logic      [7:0] O_SFR_RDATA,
  // clock control bits held outside
  input  wire logic       I_HIGH_FAST_SEL,
  input  wire logic       I_LOW_FAST_SEL,
  // external oscillator pin
  input  wire logic       I_EXT_OSC,
  // interrupt system
  input  wire logic       I_TIMER_IRQ_EN,
  output logic            O_IRQ
);
  localparam int EXT_W = $clog2(EXT_DIV);
  localparam int SYS_W = $clog2(SYS_DIV);
  localparam logic [EXT_W-1:0] EXT_LAST = EXT_W'(EXT_DIV - 1);
  localparam logic [SYS_W-1:0] SYS_LAST = SYS_W'(SYS_DIV - 1);

  // elaboration-time refusal of ratios the prescalers cannot serve
  if (SYS_DIV < 2 || EXT_DIV < 2 || (EXT_DIV & (EXT_DIV - 1)) != 0)
  begin
    $error("divide ratios unsupported");
  end

  tcl_ctrl_t        ctrl_q;
  tcl_ctrl_t        ctrl_d;
  tcl_sfr_t         bus;
  logic [15:0]      count_q;
  logic [15:0]      count_d;
  logic [15:0]      reload_q;
  logic [15:0]      reload_d;
  logic [SYS_W-1:0] sys_cnt_q;
  logic [EXT_W-1:0] ext_cnt_q;
  logic [2:0]       osc_sync_q;
  logic [7:0]       rdata_q;
  logic             irq_q;

  assign bus = '{wr: I_SFR_WR, addr: I_SFR_ADDR, wdata: I_SFR_WDATA};

  // address decode
  wire wr_ctrl = bus.wr && (bus.addr == ADDR_CTRL);
  wire wr_rl_lo = bus.wr && (bus.addr == ADDR_RELOAD_LO);
  wire wr_rl_hi = bus.wr && (bus.addr == ADDR_RELOAD_HI);
  wire wr_cnt_lo = bus.wr && (bus.addr == ADDR_COUNT_LO);
  wire wr_cnt_hi = bus.wr && (bus.addr == ADDR_COUNT_HI);

  // prescaled ticks; the oscillator passes two flops before use
  wire osc_rise = osc_sync_q[1] && !osc_sync_q[2];
  wire sys_tick = (sys_cnt_q == SYS_LAST);
  // one tick per EXT_DIV rising edges of the synchronised oscillator
  wire ext_tick = osc_rise && (ext_cnt_q == EXT_LAST);
  wire slow_tick = ctrl_q.ext_clock_select ? ext_tick : sys_tick;
  wire lo_tick = I_LOW_FAST_SEL ? 1'b1 : slow_tick;
  wire hi_tick = I_HIGH_FAST_SEL ? 1'b1 : slow_tick;

  wire split = ctrl_q.split_mode_select;
  wire run = ctrl_q.run_control;
  // 16-bit mode counts on the low byte clock select
  wire inc16 = !split && run && lo_tick;
  wire inc_lo = split ? lo_tick : inc16;
  wire inc_hi = split && run && hi_tick;
  wire lo_ovf = inc_lo && (count_q[7:0] == BYTE_MAX);
  wire hi_ovf16 = inc16 && (count_q == WORD_MAX);
  wire hi_ovf8 = inc_hi && (count_q[15:8] == BYTE_MAX);
  wire hi_ovf = hi_ovf16 || hi_ovf8;
  wire cap_ev = ctrl_q.capture_mode_enable && ext_tick;
  wire [15:0] count_inc = count_q + 16'h0001;
  wire [7:0] lo_inc = count_q[7:0] + 8'h01;
  wire [7:0] hi_inc = count_q[15:8] + 8'h01;

  wire irq_d = I_TIMER_IRQ_EN && (ctrl_q.high_overflow_flag
    || (ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag));

  wire [7:0] rd_mux =
    (bus.addr == ADDR_CTRL)      ? ctrl_q :
    (bus.addr == ADDR_RELOAD_LO) ? reload_q[7:0] :
    (bus.addr == ADDR_RELOAD_HI) ? reload_q[15:8] :
    (bus.addr == ADDR_COUNT_LO)  ? count_q[7:0] :
    (bus.addr == ADDR_COUNT_HI)  ? count_q[15:8] : READ_UNMAPPED;

  // control register: hardware set wins over a software clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = tcl_ctrl_t'(bus.wdata);
    ctrl_d.unused = 1'b0;
    ctrl_d.high_overflow_flag = ctrl_d.high_overflow_flag
      || hi_ovf || cap_ev;
    ctrl_d.low_overflow_flag = ctrl_d.low_overflow_flag || lo_ovf;
  end

  // counter: software writes take precedence over counting
  always_comb
  begin
    count_d = count_q;
    if (hi_ovf16)
      count_d = reload_q;
    else if (inc16)
      count_d = count_inc;
    else
    begin
      if (lo_ovf)
        count_d[7:0] = reload_q[7:0];
      else if (inc_lo)
        count_d[7:0] = lo_inc;
      if (hi_ovf8)
        count_d[15:8] = reload_q[15:8];
      else if (inc_hi)
        count_d[15:8] = hi_inc;
    end
    if (wr_cnt_lo)
      count_d[7:0] = bus.wdata;
    if (wr_cnt_hi)
      count_d[15:8] = bus.wdata;
  end

  // reload: a capture beats a same-cycle software write
  always_comb
  begin
    reload_d = reload_q;
    if (wr_rl_lo)
      reload_d[7:0] = bus.wdata;
    if (wr_rl_hi)
      reload_d[15:8] = bus.wdata;
    if (cap_ev)
      reload_d = count_q;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      osc_sync_q <= 3'h0;
    else
      osc_sync_q <= {osc_sync_q[1:0], I_EXT_OSC};
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sys_cnt_q <= '0;
      ext_cnt_q <= '0;
    end
    else
    begin
      sys_cnt_q <= sys_tick ? '0 : sys_cnt_q + SYS_W'(1);
      if (osc_rise)
        ext_cnt_q <= ext_cnt_q + EXT_W'(1);
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ctrl_q   <= tcl_ctrl_t'(CTRL_RESET);
      count_q  <= {BYTE_RESET, BYTE_RESET};
      reload_q <= {BYTE_RESET, BYTE_RESET};
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      reload_q <= reload_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rdata_q <= READ_UNMAPPED;
      irq_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rd_mux;
      irq_q   <= irq_d;
    end
  end

  assign O_SFR_RDATA = rdata_q;
  assign O_IRQ = irq_q;

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);

  property p_flag_sticky;
    ctrl_q.high_overflow_flag && !wr_ctrl |=> ctrl_q.high_overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("high flag dropped without a write");

  property p_low_sticky;
    ctrl_q.low_overflow_flag && !wr_ctrl |=> ctrl_q.low_overflow_flag;
  endproperty
  a_low_sticky: assert property (p_low_sticky)
    else $error("low flag dropped without a write");

  property p_split_high_halt;
    split && !run && !wr_cnt_hi |=> $stable(count_q[15:8]);
  endproperty
  a_split_high_halt: assert property (p_split_high_halt)
    else $error("halted split high byte moved");

  property p_wrap16;
    !split && run && lo_tick && count_q == WORD_MAX
      && !wr_cnt_lo && !wr_cnt_hi
    |=> ctrl_q.high_overflow_flag && count_q == $past(reload_q);
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not reload and flag");

  property p_low_flag;
    lo_ovf |=> ctrl_q.low_overflow_flag;
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("low wrap did not set low flag");

  property p_irq_high;
    I_TIMER_IRQ_EN && ctrl_q.high_overflow_flag |=> O_IRQ;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("high flag did not raise interrupt");

  property p_irq_low;
    I_TIMER_IRQ_EN && ctrl_q.low_overflow_flag
      && !ctrl_q.low_byte_irq_enable && !ctrl_q.high_overflow_flag
    |=> !O_IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("low flag interrupted while not enabled");

  property p_unused_zero;
    wr_ctrl |=> ##1
      ($past(bus.addr) != ADDR_CTRL || !O_SFR_RDATA[BIT_UNUSED]);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bit read as one");

  property p_halt16;
    !split && !run && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_q);
  endproperty
  a_halt16: assert property (p_halt16)
    else $error("halted 16-bit timer moved");

  property p_split_low_runs;
    split && !run && lo_tick && count_q[7:0] != BYTE_MAX && !wr_cnt_lo
    |=> count_q[7:0] == $past(count_q[7:0]) + 8'h01;
  endproperty
  a_split_low_runs: assert property (p_split_low_runs)
    else $error("split low byte did not count");

  property p_split_reload;
    split && lo_ovf && !wr_cnt_lo |=> count_q[7:0] == $past(reload_q[7:0]);
  endproperty
  a_split_reload: assert property (p_split_reload)
    else $error("split low byte did not reload");

  property p_capture;
    cap_ev |=> reload_q == $past(count_q) && ctrl_q.high_overflow_flag;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy count");

  property p_sys_spacing;
    sys_tick |=> !sys_tick [*8];
  endproperty
  a_sys_spacing: assert property (p_sys_spacing)
    else $error("system prescaler ticks too close");
endmodule

// ==== bench/tcl_timer3_ctrl_tb.sv ====
// self-checking testbench for the timer control logic
`timescale 1ns/1ps
module tcl_timer3_ctrl_tb;
  import tcl_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        hi_fast;
  logic        lo_fast;
  logic        osc;
  logic        irq_en;
  logic        irq;
  int          errors;
  int          checks_done;
  logic [7:0]  v;
  logic [7:0]  w;
  logic [15:0] rl;

  tcl_timer3_ctrl dut (
    .I_CLOCK         (clk),
    .I_RST_N         (rst_n),
    .I_SFR_ADDR      (addr),
    .I_SFR_WR        (wr),
    .I_SFR_WDATA     (wdata),
    .O_SFR_RDATA     (rdata),
    .I_HIGH_FAST_SEL (hi_fast),
    .I_LOW_FAST_SEL  (lo_fast),
    .I_EXT_OSC       (osc),
    .I_TIMER_IRQ_EN  (irq_en),
    .O_IRQ           (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // bit 1 never holds a one
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & 8'hfd;
  endfunction

  function automatic logic irq_exp(input logic en, input logic [7:0] d);
    return en & (d[7] | (d[5] & d[6]));
  endfunction

  // every drive lands 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // trailing idle cycle keeps back-to-back writes from re-driving wr
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    cyc(1);
    d = rdata;
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
  endtask

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    rd_reg(ADDR_CTRL, v);
    while (v[b] !== 1'b1 && n < 3000)
    begin
      rd_reg(ADDR_CTRL, v);
      n++;
    end
    if (n >= 3000)
    begin
      errors++;
      $display("[FAIL] %0t flag wait timed out", $time);
      conclude();
    end
  endtask

  task automatic osc_edges(input int n);
    repeat (n)
    begin
      osc = 1'b1;
      cyc(4);
      osc = 1'b0;
      cyc(4);
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    hi_fast = 1'b0;
    lo_fast = 1'b0;
    osc = 1'b0;
    irq_en = 1'b0;
    errors = 0;
    checks_done = 0;
    void'($urandom(33832));
    #1;
    do_reset();
    for (int a = 8'h90; a <= 8'h95; a++)
    begin
      rd_reg(8'(a), v);
      check(v, 8'h00);
    end
    $display("reset values done");
    repeat (8)
    begin
      w = 8'($urandom);
      irq_en = 1'($urandom);
      wr_reg(ADDR_CTRL, w);
      wr_reg(8'h90, ~w);
      rd_reg(ADDR_CTRL, v);
      check(v, ctrl_exp(w));
      check({7'h00, irq}, {7'h00, irq_exp(irq_en, w)});
    end
    irq_en = 1'b1;
    wr_reg(ADDR_CTRL, 8'h40);
    check({7'h00, irq}, 8'h00);
    wr_reg(ADDR_CTRL, 8'h60);
    check({7'h00, irq}, 8'h01);
    wr_reg(ADDR_CTRL, 8'h00);
    $display("control writes done");
    rl = {8'($urandom), 8'($urandom) & 8'h7f};
    lo_fast = 1'b1;
    irq_en = 1'b1;
    wr_reg(ADDR_RELOAD_LO, rl[7:0]);
    wr_reg(ADDR_RELOAD_HI, rl[15:8]);
    wr_reg(ADDR_COUNT_LO, 8'hf0);
    wr_reg(ADDR_COUNT_HI, 8'hff);
    wr_reg(ADDR_CTRL, 8'h04);
    wait_bit(BIT_HIGH_FLAG);
    check(v & 8'hc0, 8'hc0);
    rd_reg(ADDR_COUNT_HI, v);
    check(v, rl[15:8]);
    check({7'h00, irq}, 8'h01);
    cyc(20);
    rd_reg(ADDR_CTRL, v);
    check(v & 8'hc0, 8'hc0);
    wr_reg(ADDR_CTRL, 8'h00);
    rd_reg(ADDR_COUNT_LO, w);
    cyc(30);
    rd_reg(ADDR_COUNT_LO, v);
    check(v, w);
    rd_reg(ADDR_CTRL, v);
    check(v, 8'h00);
    $display("word wrap done");
    hi_fast = 1'b1;
    wr_reg(ADDR_COUNT_HI, 8'h77);
    wr_reg(ADDR_RELOAD_LO, 8'h50);
    wr_reg(ADDR_COUNT_LO, 8'hfa);
    wr_reg(ADDR_CTRL, 8'h28);
    wait_bit(BIT_LOW_FLAG);
    check(v & 8'h80, 8'h00);
    check({7'h00, irq}, 8'h01);
    rd_reg(ADDR_COUNT_HI, v);
    check(v, 8'h77);
    rd_reg(ADDR_COUNT_LO, v);
    check(v & 8'hf8, 8'h50);
    wr_reg(ADDR_CTRL, 8'h2c);
    wait_bit(BIT_HIGH_FLAG);
    check(v & 8'h80, 8'h80);
    $display("split mode done");
    do_reset();
    hi_fast = 1'b0;
    lo_fast = 1'b0;
    wr_reg(ADDR_CTRL, 8'h0d);
    osc_edges(16);
    cyc(6);
    rd_reg(ADDR_COUNT_LO, v);
    check(v, 8'(16 / EXT_DIVIDE));
    rd_reg(ADDR_COUNT_HI, v);
    check(v, 8'(16 / EXT_DIVIDE));
    rd_reg(ADDR_CTRL, v);
    check(v & 8'h80, 8'h00);
    wr_reg(ADDR_CTRL, 8'h08);
    rd_reg(ADDR_COUNT_LO, w);
    cyc(10 * SYS_DIVIDE - 1);
    rd_reg(ADDR_COUNT_LO, v);
    check(v - w, 8'd10);
    $display("clock select done");
    do_reset();
    lo_fast = 1'b1;
    wr_reg(ADDR_CTRL, 8'h14);
    osc_edges(8);
    cyc(6);
    rd_reg(ADDR_CTRL, v);
    check(v & 8'h80, 8'h80);
    rd_reg(ADDR_RELOAD_LO, w);
    rd_reg(ADDR_COUNT_LO, v);
    check({7'h00, w > 8'h20 && w < v}, 8'h01);
    $display("capture done");
    conclude();
  end
endmodule
